//--- core/dcrc_ctrl.sv
// control-register controller: arbitration, indirect access, lock and status register
//
// How it works
// [R01] block of 256 located by two-bit tieoff
// [R02] offsets routed to controller, coprocessor, memory, crossbar, dma
// [R03] twelve-bit indirect address register, read and write
// [R04] unused indirect address bits read zero
// [R05] proxy offset uses stored address for decoding
// [R06] proxy reads and writes reach stored target
// [R07] processor lock bit: processor writes, both read
// [R08] processor auto lock flag, read only
// [R09] external lock bit: external writes, both read
// [R10] external auto lock flag, read only
// [R11] auto-lock enable, default from attribute
// [R12] external timing mode bit, read only
// [R13] never both masters holding the lock
// [R14] expiry flags set on timeout, cleared by writes
// [R15] unused control bits read zero
// [R16] reserved offsets complete, read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module dcrc_ctrl
  import dcrc_pkg::*;
#(
  parameter logic LOCK_ENABLE_ATTR = AUTOLOCK_RST,
  parameter logic EXT_MODE_ATTR = EXT_MODE_RST,
  parameter int TIMEOUT_CYCLES = TIMEOUT_DEFAULT
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] block_base_tieoff,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  output logic ext_ack,
  output logic [31:0] ext_rdata,
  output logic slv_req,
  output logic slv_we,
  output logic [ADDR_W-1:0] slv_addr,
  output logic [31:0] slv_wdata,
  output logic [SEL_W-1:0] slv_sel,
  input wire logic slv_ack,
  input wire logic [31:0] slv_rdata
);
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} dcrc_state_t;

  dcrc_state_t state_r;
  logic owner_cpu_r, proxy_r;
  logic [31:0] rdata_r;
  logic [ADDR_W-1:0] ind_addr_r;
  logic cpu_lock_r, cpu_alock_r, ext_lock_r, ext_alock_r, autolock_en_r;
  logic cpu_expired_r, ext_expired_r;
  logic [CNT_W-1:0] wait_cnt_r;
  logic pick_cpu, pick_ext, start, req_we, is_proxy, to_slave, local_hit;
  logic wr_ind, wr_ctrl, expire, finish, locked_by_other;
  logic [ADDR_W-1:0] req_addr, eff_addr;
  logic [31:0] req_wdata, ctrl_word, local_rdata;
  dcrc_region_t direct_region, eff_region;

  function automatic logic [SEL_W-1:0] sel_of(input dcrc_region_t r);
    logic [SEL_W-1:0] s;
    s = '0;
    case (r)
      REG_APU: s[SEL_APU] = 1'b1;
      REG_MCI: s[SEL_MCI] = 1'b1;
      REG_XBAR: s[SEL_XBAR] = 1'b1;
      REG_DMA: s[SEL_DMA] = 1'b1;
      REG_OUTSIDE: s[SEL_OUTSIDE] = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // arbitration: a locked bus serves only its holder
  // ----------------------------------------
  assign pick_cpu = cpu_req && !(ext_lock_r || ext_alock_r);
  assign pick_ext = ext_req && !(cpu_lock_r || cpu_alock_r) && !pick_cpu;
  assign start = (state_r == ST_IDLE) && (pick_cpu || pick_ext);
  assign req_we = pick_cpu ? cpu_we : ext_we;
  assign req_addr = pick_cpu ? cpu_addr : ext_addr;
  assign req_wdata = pick_cpu ? cpu_wdata : ext_wdata;

  // ----------------------------------------
  // address substitution for the proxy location
  // ----------------------------------------
  dcrc_route u_direct (
    .addr(req_addr),
    .block_base_tieoff(block_base_tieoff),
    .region(direct_region)
  );
  assign is_proxy = (direct_region == REG_CTRL) && (req_addr[7:0] == OFF_PROXY);
  assign eff_addr = is_proxy ? ind_addr_r : req_addr; // [R05]
  dcrc_route u_eff (
    .addr(eff_addr),
    .block_base_tieoff(block_base_tieoff),
    .region(eff_region)
  );
  assign to_slave = !(eff_region == REG_CTRL || eff_region == REG_RSVD); // [R06]
  // a proxy pointing at itself behaves as reserved
  assign local_hit = (eff_region == REG_CTRL) && (eff_addr[7:0] != OFF_PROXY);
  assign wr_ind = start && req_we && local_hit && (eff_addr[7:0] == OFF_IND_ADDR);
  assign wr_ctrl = start && req_we && local_hit && (eff_addr[7:0] == OFF_CTRL);
  assign expire = (state_r == ST_WAIT) && !slv_ack && (wait_cnt_r == CNT_LAST);
  assign finish = (state_r == ST_DONE);
  assign locked_by_other = pick_cpu ? (ext_lock_r || ext_alock_r) : (cpu_lock_r || cpu_alock_r);

  // ----------------------------------------
  // control word and local read data
  // ----------------------------------------
  always_comb
  begin
    ctrl_word = '0; // [R15]
    ctrl_word[CPU_LOCK_BIT] = cpu_lock_r;
    ctrl_word[CPU_ALOCK_BIT] = cpu_alock_r; // [R08]
    ctrl_word[EXT_LOCK_BIT] = ext_lock_r;
    ctrl_word[EXT_ALOCK_BIT] = ext_alock_r; // [R10]
    ctrl_word[AUTOLOCK_BIT] = autolock_en_r;
    ctrl_word[EXT_MODE_BIT] = EXT_MODE_ATTR; // [R12]
    ctrl_word[CPU_EXPIRED_BIT] = cpu_expired_r;
    ctrl_word[EXT_EXPIRED_BIT] = ext_expired_r;
    if (!local_hit)
      local_rdata = '0; // [R16]
    else if (eff_addr[7:0] == OFF_IND_ADDR)
      local_rdata = {20'h0, ind_addr_r}; // [R04]
    else
      local_rdata = ctrl_word;
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE: if (start) state_r <= to_slave ? ST_WAIT : ST_DONE;
        ST_WAIT: if (slv_ack || expire) state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      owner_cpu_r <= 1'b0;
      proxy_r <= 1'b0;
    end
    else if (start)
    begin
      owner_cpu_r <= pick_cpu;
      proxy_r <= is_proxy;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wait_cnt_r <= '0;
    else if (state_r == ST_WAIT)
      wait_cnt_r <= wait_cnt_r + 1'b1;
    else
      wait_cnt_r <= '0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= '0;
    else if (start)
      rdata_r <= to_slave ? 32'h0 : local_rdata;
    else if (state_r == ST_WAIT && slv_ack && !slv_we)
      rdata_r <= slv_rdata;
  end

  // ----------------------------------------
  // slave side request
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slv_req <= 1'b0;
      slv_we <= 1'b0;
      slv_addr <= '0;
      slv_wdata <= '0;
      slv_sel <= '0;
    end
    else if (start && to_slave)
    begin
      slv_req <= 1'b1;
      slv_we <= req_we;
      slv_addr <= eff_addr; // [R05]
      slv_wdata <= req_wdata;
      slv_sel <= sel_of(eff_region); // [R02]
    end
    else if (slv_ack || expire)
      slv_req <= 1'b0;
  end

  // ----------------------------------------
  // indirect address and control register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ind_addr_r <= IND_ADDR_RST;
    else if (wr_ind)
      ind_addr_r <= req_wdata[ADDR_W-1:0]; // [R03]
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_lock_r <= LOCK_RST;
      ext_lock_r <= LOCK_RST;
      autolock_en_r <= LOCK_ENABLE_ATTR;
    end
    else if (wr_ctrl)
    begin
      autolock_en_r <= req_wdata[AUTOLOCK_BIT]; // [R11]
      if (pick_cpu)
        cpu_lock_r <= req_wdata[CPU_LOCK_BIT] && !locked_by_other; // [R07] [R13]
      else
        ext_lock_r <= req_wdata[EXT_LOCK_BIT] && !locked_by_other; // [R09] [R13]
    end
  end

  // auto lock held from a direct address write until the proxy access ends
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_alock_r <= LOCK_RST;
      ext_alock_r <= LOCK_RST;
    end
    else if (wr_ind && !is_proxy && autolock_en_r)
    begin
      cpu_alock_r <= pick_cpu; // [R08]
      ext_alock_r <= !pick_cpu; // [R10]
    end
    else if ((finish && proxy_r) || !autolock_en_r)
    begin
      cpu_alock_r <= 1'b0;
      ext_alock_r <= 1'b0;
    end
  end

  // set wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_expired_r <= LOCK_RST;
      ext_expired_r <= LOCK_RST;
    end
    else
    begin
      if (expire && owner_cpu_r)
        cpu_expired_r <= 1'b1; // [R14]
      else if (wr_ctrl && !locked_by_other)
        cpu_expired_r <= 1'b0; // [R14]
      if (expire && !owner_cpu_r)
        ext_expired_r <= 1'b1; // [R14]
      else if (wr_ctrl && !locked_by_other)
        ext_expired_r <= 1'b0; // [R14]
    end
  end

  assign cpu_ack = finish && owner_cpu_r;
  assign ext_ack = finish && !owner_cpu_r;
  assign cpu_rdata = rdata_r;
  assign ext_rdata = rdata_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  lock_exclusive_a: assert property (!((cpu_lock_r || cpu_alock_r) && (ext_lock_r || ext_alock_r))) // [R13]
    else $error("both masters hold the lock");
  ind_read_zero_a: assert property (start && !req_we && local_hit && eff_addr[7:0] == OFF_IND_ADDR
    |=> cpu_rdata == {20'h0, $past(ind_addr_r)} && (cpu_ack || ext_ack)) // [R04]
    else $error("indirect address read wrong");
  proxy_target_a: assert property (start && is_proxy && to_slave
    |=> slv_req && slv_addr == $past(ind_addr_r)) // [R05]
    else $error("proxy access not sent to stored address");
  proxy_write_a: assert property (start && is_proxy && to_slave && req_we
    |=> slv_we && slv_wdata == $past(req_wdata)) // [R06]
    else $error("proxy write data lost");
  cpu_lock_owner_a: assert property (start && !pick_cpu |=> $stable(cpu_lock_r)) // [R07]
    else $error("external master changed processor lock");
  ext_lock_owner_a: assert property (start && pick_cpu |=> $stable(ext_lock_r)) // [R09]
    else $error("processor changed external lock");
  alock_enable_a: assert property ($rose(cpu_alock_r) || $rose(ext_alock_r) |-> $past(autolock_en_r)) // [R08]
    else $error("auto lock taken while disabled");
  expiry_set_a: assert property (expire && owner_cpu_r |=> cpu_expired_r && cpu_ack ##1 !cpu_ack) // [R14]
    else $error("processor expiry not flagged");
  rsvd_read_a: assert property (start && !to_slave && !local_hit |=> rdata_r == 32'h0 ##1 state_r == ST_IDLE) // [R16]
    else $error("reserved access did not read zero");
  ctrl_unused_a: assert property (start && !req_we && local_hit && eff_addr[7:0] == OFF_CTRL
    |=> rdata_r[29:6] == 24'h0) // [R15]
    else $error("unused control bits set");
endmodule // dcrc_ctrl
`default_nettype wire

//--- core/dcrc_pkg.sv
// constants and types of the control-register controller
package dcrc_pkg;
  // register offsets inside the 256-location block
  localparam logic [7:0] OFF_IND_ADDR = 8'h00;
  localparam logic [7:0] OFF_PROXY = 8'h01;
  localparam logic [7:0] OFF_CTRL = 8'h02;
  localparam logic [7:0] APU_LO = 8'h04;
  localparam logic [7:0] APU_HI = 8'h05;
  localparam logic [7:0] MCI_LO = 8'h10;
  localparam logic [7:0] MCI_HI = 8'h12;
  localparam logic [7:0] XBAR_LO = 8'h20;
  localparam logic [7:0] XBAR_HI = 8'h5f;
  localparam logic [7:0] DMA_BASE = 8'h80;
  localparam logic [7:0] DMA_STRIDE = 8'h18;
  localparam logic [7:0] DMA_SPAN = 8'h10;
  localparam int DMA_COUNT = 4;
  // address layout: upper_address_lines [11:10], lower_address_lines [9:0]
  localparam int ADDR_W = 12;
  localparam int BLK_LSB = 8;
  // control register field positions
  localparam int CPU_LOCK_BIT = 0;
  localparam int CPU_ALOCK_BIT = 1;
  localparam int EXT_LOCK_BIT = 2;
  localparam int EXT_ALOCK_BIT = 3;
  localparam int AUTOLOCK_BIT = 4;
  localparam int EXT_MODE_BIT = 5;
  localparam int CPU_EXPIRED_BIT = 30;
  localparam int EXT_EXPIRED_BIT = 31;
  // reset values
  localparam logic [11:0] IND_ADDR_RST = 12'h000;
  localparam logic LOCK_RST = 1'b0;
  localparam logic AUTOLOCK_RST = 1'b1;
  localparam logic EXT_MODE_RST = 1'b0;
  // slave wait limit before an access is declared expired
  localparam int TIMEOUT_DEFAULT = 256;
  // one-hot slave select positions
  localparam int SEL_APU = 0;
  localparam int SEL_MCI = 1;
  localparam int SEL_XBAR = 2;
  localparam int SEL_DMA = 3;
  localparam int SEL_OUTSIDE = 4;
  localparam int SEL_W = 5;

  typedef enum logic [2:0] {
    REG_CTRL, REG_RSVD, REG_APU, REG_MCI, REG_XBAR, REG_DMA, REG_OUTSIDE
  } dcrc_region_t;
endpackage

//--- core/dcrc_route.sv
// address decoder of the relocatable 256-location block
`timescale 1ns/1ps
`default_nettype none
module dcrc_route
  import dcrc_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] block_base_tieoff,
  output var dcrc_region_t region
);
  logic [7:0] off;
  logic [DMA_COUNT-1:0] dma_hit;
  logic in_block;

  assign off = addr[7:0];
  // block sits at tieoff*256 in the low 10-bit space
  assign in_block = (addr[11:10] == 2'b00) && (addr[9:BLK_LSB] == block_base_tieoff); // [R01]

  // ----------------------------------------
  // dma engine windows
  // ----------------------------------------
  for (genvar g = 0; g < DMA_COUNT; g++)
  begin : g_dma
    localparam logic [7:0] LO = 8'(int'(DMA_BASE) + g * int'(DMA_STRIDE));
    assign dma_hit[g] = (off >= LO) && (off <= LO + DMA_SPAN);
  end

  always_comb
  begin
    if (!in_block)
      region = REG_OUTSIDE;
    else if (off <= OFF_CTRL)
      region = REG_CTRL; // [R02]
    else if (off >= APU_LO && off <= APU_HI)
      region = REG_APU;
    else if (off >= MCI_LO && off <= MCI_HI)
      region = REG_MCI;
    else if (off >= XBAR_LO && off <= XBAR_HI)
      region = REG_XBAR;
    else if (|dma_hit)
      region = REG_DMA;
    else
      region = REG_RSVD; // [R16]
  end
endmodule // dcrc_route
`default_nettype wire

//--- test/dcrc_slv_model.sv
// behavioural slave behind the controller's slave port
`timescale 1ns/1ps
`default_nettype none
module dcrc_slv_model
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slv_req,
  input wire logic slv_we,
  input wire logic [11:0] slv_addr,
  input wire logic [31:0] slv_wdata,
  input wire logic [4:0] slv_sel,
  input wire logic stall,
  input wire logic [1:0] dly,
  output logic slv_ack,
  output logic [31:0] slv_rdata,
  output logic [11:0] last_addr,
  output logic [4:0] last_sel,
  output logic [31:0] last_wdata
);
  logic [31:0] mem [0:4095];
  logic [1:0] cnt;
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = {12'(i), 8'h5a, ~12'(i)};
  end
  // ack after dly wait cycles; stall never answers
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slv_ack <= 1'b0;
      cnt <= 2'h0;
      slv_rdata <= 32'h0;
    end
    else if (!slv_ack && slv_req && !stall && cnt >= dly)
    begin
      slv_ack <= 1'b1;
      cnt <= 2'h0;
      last_addr <= slv_addr;
      last_sel <= slv_sel;
      last_wdata <= slv_wdata;
      slv_rdata <= mem[slv_addr];
      if (slv_we)
        mem[slv_addr] <= slv_wdata;
    end
    else
    begin
      // released data toggles so nothing stale passes
      slv_ack <= 1'b0;
      slv_rdata <= ~slv_rdata;
      cnt <= (slv_req && !slv_ack && !stall) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule // dcrc_slv_model
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench of the control-register controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcrc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] tie = 2'h0;
  logic cpu_req = 1'b0, cpu_we = 1'b0, ext_req = 1'b0, ext_we = 1'b0, stall = 1'b0;
  logic [11:0] cpu_addr = 12'h0, ext_addr = 12'h0, t, last_addr, slv_addr;
  logic [31:0] cpu_wdata = 32'h0, ext_wdata = 32'h0, cpu_rdata, ext_rdata, slv_wdata, slv_rdata, q, d, last_wdata;
  logic cpu_ack, ext_ack, slv_req, slv_we, slv_ack;
  logic [4:0] slv_sel, last_sel;
  logic [1:0] dly = 2'h0;
  logic [7:0] rsv [5] = '{8'h03, 8'h60, 8'h91, 8'he0, 8'hff};
  logic [7:0] sa [4] = '{8'h04, 8'h10, 8'h40, 8'h98};
  int miscompares = 0, comparisons = 0, cyc = 0;

  always #20 sys_clk = ~sys_clk;

  dcrc_ctrl #(.TIMEOUT_CYCLES(8)) dut (.sys_clk(sys_clk), .resetn(resetn), .block_base_tieoff(tie),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata), .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata), .slv_req(slv_req), .slv_we(slv_we), .slv_addr(slv_addr),
    .slv_wdata(slv_wdata), .slv_sel(slv_sel), .slv_ack(slv_ack), .slv_rdata(slv_rdata));

  dcrc_slv_model slv (.sys_clk(sys_clk), .resetn(resetn), .slv_req(slv_req), .slv_we(slv_we),
    .slv_addr(slv_addr), .slv_wdata(slv_wdata), .slv_sel(slv_sel), .stall(stall), .dly(dly), .slv_ack(slv_ack),
    .slv_rdata(slv_rdata), .last_addr(last_addr), .last_sel(last_sel), .last_wdata(last_wdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] pat(input logic [11:0] a);
    return {a, 8'h5a, ~a};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask

  // request held until ack, dropped in the ack cycle
  task automatic acc(input bit x, input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(negedge sys_clk);
    dly = 2'($urandom % 4);
    {ext_req, ext_we, ext_addr, ext_wdata} = x ? {1'b1, w, a, wd} : 46'h0;
    {cpu_req, cpu_we, cpu_addr, cpu_wdata} = x ? 46'h0 : {1'b1, w, a, wd};
    while (!got && n < 300)
    begin
      @(negedge sys_clk);
      n++;
      got = x ? (ext_ack === 1'b1) : (cpu_ack === 1'b1);
    end
    rd = x ? ext_rdata : cpu_rdata;
    cpu_req = 1'b0;
    ext_req = 1'b0;
    if (!got)
      chk("ack", 32'h1, 32'h0);
  endtask

  task automatic rdc(input bit x, input logic [7:0] o, input logic [31:0] e);
    acc(x, 1'b0, {2'b00, tie, o}, 32'h0, q);
    chk($sformatf("read %h", o), e, q);
  endtask

  task automatic wr(input bit x, input logic [7:0] o, input logic [31:0] v);
    logic [31:0] u;
    acc(x, 1'b1, {2'b00, tie, o}, v, u);
  endtask

  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(28433));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    rdc(0, 8'h02, 32'h10);
    rdc(1, 8'h02, 32'h10);
    rdc(0, 8'h00, 32'h0);
    $display("test reset done");
    foreach (rsv[i])
    begin
      wr(0, rsv[i], $urandom);
      rdc(0, rsv[i], 32'h0);
    end
    $display("test reserved done");
    d = $urandom;
    wr(0, 8'h00, d);
    rdc(0, 8'h00, {20'h0, d[11:0]});
    rdc(0, 8'h02, 32'h12);
    t = 12'h011 + 12'($urandom % 2);
    wr(0, 8'h00, {20'h0, t});
    d = $urandom;
    wr(0, 8'h01, d);
    chk("slave addr", {20'h0, t}, {20'h0, last_addr});
    chk("slave sel", 32'h2, {27'h0, last_sel});
    chk("slave data", d, last_wdata);
    rdc(0, 8'h02, 32'h10);
    rdc(0, 8'h01, d);
    t = 12'h020 + 12'($urandom % 64);
    wr(1, 8'h00, {20'h0, t});
    rdc(1, 8'h02, 32'h18);
    rdc(1, 8'h01, pat(t));
    chk("proxy sel", 32'h4, {27'h0, last_sel});
    rdc(0, 8'h02, 32'h10);
    $display("test indirect done");
    foreach (sa[i])
    begin
      rdc(0, sa[i], pat({4'h0, sa[i]}));
      chk("area sel", 32'h1 << i, {27'h0, last_sel});
    end
    $display("test areas done");
    wr(0, 8'h02, 32'h0);
    rdc(0, 8'h02, 32'h0);
    wr(0, 8'h00, 32'h0);
    rdc(0, 8'h02, 32'h0);
    wr(0, 8'h02, 32'h10);
    wr(0, 8'h02, 32'h11);
    rdc(0, 8'h02, 32'h11);
    wr(0, 8'h02, 32'h10);
    wr(1, 8'h02, 32'h14);
    rdc(1, 8'h02, 32'h14);
    wr(1, 8'h02, 32'h10);
    wr(0, 8'h02, 32'h14);
    rdc(1, 8'h02, 32'h10);
    wr(1, 8'h02, 32'h11);
    rdc(0, 8'h02, 32'h10);
    $display("test locks done");
    stall = 1'b1;
    acc(0, 1'b0, 12'h010, 32'h0, q);
    acc(1, 1'b0, 12'h011, 32'h0, q);
    stall = 1'b0;
    rdc(1, 8'h02, 32'hc000_0010);
    wr(1, 8'h02, 32'h10);
    rdc(0, 8'h02, 32'h10);
    $display("test expiry done");
    for (int b = 0; b < 4; b++)
    begin
      tie = 2'(b);
      d = $urandom;
      wr(0, 8'h00, d);
      rdc(0, 8'h00, {20'h0, d[11:0]});
      acc(0, 1'b0, {2'b00, ~tie, 8'h10}, 32'h0, q);
      chk("outside", pat({2'b00, ~tie, 8'h10}), q);
      chk("outside sel", 32'h10, {27'h0, last_sel});
    end
    $display("test base done");
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
